// >>> design/sdclk_pkg.sv
// types shared by the serial clock generator and its users
package sdclk_pkg;

	// ----------------------------------------------------------------
	// reference source selection
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SDCLK_REF_PIN,
		SDCLK_REF_PLL,
		SDCLK_REF_CORE
	} sdclk_ref_t;

	// ----------------------------------------------------------------
	// run-time configuration, taken on cfg_load
	// ----------------------------------------------------------------
	typedef struct packed {
		sdclk_ref_t ref_sel;
		logic [3:0] mult;
		logic [3:0] factor_a;
		logic [3:0] factor_b;
		logic [3:0] phase;
		logic bank_up_en;
		logic bank_dn_en;
	} sdclk_cfg_t;

	// ----------------------------------------------------------------
	// clock outputs toward the channel banks
	// ----------------------------------------------------------------
	typedef struct packed {
		logic bit_strobe;
		logic parallel_clock_out_a;
		logic parallel_clock_out_b;
		logic load_a;
		logic load_b;
		logic bank_up_active;
		logic bank_dn_active;
		logic locked;
	} sdclk_clk_t;

endpackage : sdclk_pkg

// >>> design/sdclk_regs.svh
// constants for the serial clock generator and deserializer bit mapper
`ifndef SDCLK_REGS_SVH
`define SDCLK_REGS_SVH

// ----------------------------------------------------------------
// factor limits and reset values
// ----------------------------------------------------------------
`define SDCLK_FACTOR_MIN 4'h4
`define SDCLK_FACTOR_MAX 4'hA
`define SDCLK_FACTOR_RST 4'h8
`define SDCLK_MULT_RST 4'hA
`define SDCLK_MULT_MAX 4'hA
`define SDCLK_PHASE_RST 4'h0
`define SDCLK_SEL_RST 2'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SDCLK_CLK_NS 50
`define SDCLK_TAP_COUNT 8
`define SDCLK_WORD_MAX 10
`define SDCLK_PERIOD_W 16

`endif

// >>> design/sdclk_top.sv
// serial bit clock synthesis, parallel clock division and deserializer bit mapping
// Operation
// - one generator makes bit and word clocks
// - bit tick rate equals serial bit rate
// - one bit rate, two parallel factors
// - reference changes only by manual selection
// - configuration reloadable while running
// - reference from pin, pll or core
// - center drives both banks, corner one
// - multiply forwarded clock, settable sampling phase
// - bits captured on bit clock falling edge; here each channel shifts on the bit tick delayed by its phase_sel tap
// - channel n on bits 8n-1 to 8n-8
// - each channel picks own sampling phase
// - deserialization factor four to ten bits
// - load pulse derived from deserialization factor
`include "sdclk_regs.svh"

module sdclk_top import sdclk_pkg::*; #(
	parameter int NCH = 18,
	parameter int WORD_W = 8,
	parameter bit CENTER = 1'b1
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// reference clock candidates, asynchronous
	input wire logic ref_pin,
	input wire logic ref_pll,
	input wire logic ref_core,
	// configuration from core logic
	input wire sdclk_cfg_t cfg,
	input wire logic cfg_load,
	input wire logic [NCH-1:0][2:0] phase_sel,
	// serial data, asynchronous
	input wire logic [NCH-1:0] rx_serial,
	// clock outputs
	output sdclk_clk_t clk_out,
	// parallel bus toward core
	output logic [NCH*WORD_W-1:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic rx_overflow
);

	localparam int PW = `SDCLK_PERIOD_W;
	localparam int TAPS = `SDCLK_TAP_COUNT;
	localparam int WMAX = `SDCLK_WORD_MAX;
	localparam int BUSW = NCH * WORD_W;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] ref_s1;
		logic [2:0] ref_s2;
		logic ref_prev;
		logic [NCH-1:0] dat_s1;
		logic [NCH-1:0] dat_s2;
		sdclk_cfg_t cfg;
		logic [PW-1:0] per_cnt;
		logic [PW-1:0] period;
		logic [PW-1:0] acc;
		logic [TAPS-1:0] tick_dly;
		logic [TAPS-1:0] ld_dly;
		logic [3:0] cnt_a;
		logic [3:0] cnt_b;
		logic [NCH-1:0][WMAX-1:0] sr;
		sdclk_clk_t co;
		logic out_valid;
		logic [BUSW-1:0] out_data;
		logic skid_valid;
		logic [BUSW-1:0] skid_data;
		logic overflow;
	} sdclk_state_t;

	sdclk_state_t st;
	sdclk_state_t next_st;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] clamp_factor(input logic [3:0] f);
		if (f < `SDCLK_FACTOR_MIN) begin
			return `SDCLK_FACTOR_MIN;
		end
		if (f > `SDCLK_FACTOR_MAX) begin
			return `SDCLK_FACTOR_MAX;
		end
		return f;
	endfunction : clamp_factor

	// word counter step; returns next count and flags the boundary
	function automatic logic [4:0] div_step(input logic [3:0] cnt, input logic [3:0] f);
		if (cnt >= f - 4'h1) begin
			return {1'b1, 4'h0};
		end
		return {1'b0, cnt + 4'h1};
	endfunction : div_step

	function automatic sdclk_cfg_t sanitize(input sdclk_cfg_t c);
		sdclk_cfg_t r;
		r = c;
		r.factor_a = clamp_factor(c.factor_a);
		r.factor_b = clamp_factor(c.factor_b);
		if (c.mult == 4'h0) begin
			r.mult = 4'h1;
		end else if (c.mult > `SDCLK_MULT_MAX) begin
			r.mult = `SDCLK_MULT_MAX;
		end
		if (c.ref_sel == 2'h3) begin
			r.ref_sel = SDCLK_REF_PIN;
		end
		if (!CENTER) begin
			r.bank_dn_en = 1'b0;
		end
		return r;
	endfunction : sanitize

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic ref_now;
	logic ref_rise;
	logic [PW:0] acc_sum;
	logic tick;
	logic [4:0] step_a;
	logic [4:0] step_b;
	logic [NCH-1:0][WMAX-1:0] sr_n;
	logic [BUSW-1:0] word;
	logic push;
	logic pop;
	sdclk_cfg_t rst_cfg;

	always_comb begin
		rst_cfg = '{ref_sel: SDCLK_REF_PIN, mult: `SDCLK_MULT_RST,
			factor_a: `SDCLK_FACTOR_RST, factor_b: `SDCLK_FACTOR_RST,
			phase: `SDCLK_PHASE_RST, bank_up_en: 1'b1, bank_dn_en: 1'b0};
		next_st = st;
		next_st.ref_s1 = {ref_core, ref_pll, ref_pin};
		next_st.ref_s2 = st.ref_s1;
		next_st.dat_s1 = rx_serial;
		next_st.dat_s2 = st.dat_s1;

		// only the selected source is followed; no automatic fallback
		ref_now = st.ref_s2[st.cfg.ref_sel];
		next_st.ref_prev = ref_now;
		ref_rise = ref_now & ~st.ref_prev;

		// period of the forwarded clock in system cycles
		next_st.per_cnt = ref_rise ? {{(PW-1){1'b0}}, 1'b1} : st.per_cnt + 1'b1;
		if (ref_rise) begin
			next_st.period = st.per_cnt;
		end

		// accumulator divides the reference period by mult; one tick per bit
		acc_sum = {1'b0, st.acc} + {{(PW-3){1'b0}}, st.cfg.mult};
		tick = 1'b0;
		if (ref_rise) begin
			// phase offset re-centres the tick on each reference edge
			next_st.acc = {{(PW-4){1'b0}}, st.cfg.phase};
			tick = (st.period != '0);
		end else if (st.period != '0 && acc_sum >= {1'b0, st.period}) begin
			next_st.acc = acc_sum[PW-1:0] - st.period;
			tick = 1'b1;
		end else begin
			next_st.acc = acc_sum[PW-1:0];
		end
		next_st.co.bit_strobe = tick;
		next_st.co.locked = (st.period != '0);
		next_st.tick_dly = {st.tick_dly[TAPS-2:0], tick};

		// two word dividers share the single bit tick
		step_a = div_step(st.cnt_a, st.cfg.factor_a);
		step_b = div_step(st.cnt_b, st.cfg.factor_b);
		next_st.co.load_a = 1'b0;
		next_st.co.load_b = 1'b0;
		if (tick) begin
			next_st.cnt_a = step_a[3:0];
			next_st.cnt_b = step_b[3:0];
			next_st.co.load_a = step_a[4];
			next_st.co.load_b = step_b[4];
		end
		// high for the first half of each word
		next_st.co.parallel_clock_out_a = (next_st.cnt_a < {1'b0, st.cfg.factor_a[3:1]});
		next_st.co.parallel_clock_out_b = (next_st.cnt_b < {1'b0, st.cfg.factor_b[3:1]});
		next_st.ld_dly = {st.ld_dly[TAPS-2:0], next_st.co.load_a};
		next_st.co.bank_up_active = st.cfg.bank_up_en & next_st.co.locked;
		next_st.co.bank_dn_active = st.cfg.bank_dn_en & next_st.co.locked;

		// each channel samples at its own delay after the shared tick
		for (int c = 0; c < NCH; c++) begin
			sr_n[c] = st.sr[c];
			if (st.tick_dly[phase_sel[c]]) begin
				sr_n[c] = {st.sr[c][WMAX-2:0], st.dat_s2[c]};
			end
		end
		next_st.sr = sr_n;

		// captured late enough that every tap has shifted the last bit
		word = '0;
		for (int c = 0; c < NCH; c++) begin
			for (int b = 0; b < WORD_W; b++) begin
				// first bit received lands in slice bit factor_a-1, the msb only when factor_a equals WORD_W
				// factors wider than the slice keep only the newest bits, never the neighbour's
				if (b < int'(st.cfg.factor_a)) begin
					word[c*WORD_W + b] = sr_n[c][b];
				end
			end
		end
		push = st.ld_dly[TAPS-1];

		// two-entry buffer; the serial side cannot stall, so a full buffer drops
		pop = st.out_valid & rx_ready;
		if (pop) begin
			next_st.out_valid = st.skid_valid;
			next_st.out_data = st.skid_data;
			next_st.skid_valid = 1'b0;
		end
		if (push) begin
			if (!next_st.out_valid) begin
				next_st.out_valid = 1'b1;
				next_st.out_data = word;
			end else if (!next_st.skid_valid) begin
				next_st.skid_valid = 1'b1;
				next_st.skid_data = word;
			end else begin
				next_st.overflow = 1'b1;
			end
		end

		// reload restarts dividers so the new factors start on a boundary
		if (cfg_load) begin
			next_st.cfg = sanitize(cfg);
			next_st.cnt_a = 4'h0;
			next_st.cnt_b = 4'h0;
			next_st.period = '0;
			next_st.acc = '0;
		end

		if (rst) begin
			next_st = '0;
			next_st.cfg = sanitize(rst_cfg);
		end
	end

	always_ff @(posedge clk) begin
		if (rst || ce) begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign clk_out = st.co;
	assign rx_data = st.out_data;
	assign rx_valid = st.out_valid;
	assign rx_overflow = st.overflow;

endmodule : sdclk_top

// >>> testbench/sdclk_top_assertions.sv
// concurrent checks on the serial clock generator ports
module sdclk_top_assertions import sdclk_pkg::*; #(
	parameter int NCH = 18,
	parameter int WORD_W = 8
) (
	// observed ports
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic cfg_load,
	input wire sdclk_clk_t clk_out,
	input wire logic [NCH*WORD_W-1:0] rx_data,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic rx_overflow
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> clk_out == '0 && !rx_valid)
		else $error("outputs not cleared");
	a_tick_locked: assert property (clk_out.bit_strobe |-> clk_out.locked || $past(cfg_load))
		else $error("tick while unlocked");
	a_bank_gate: assert property (clk_out.bank_dn_active |-> clk_out.locked)
		else $error("bank active unlocked");
	a_load_space: assert property (clk_out.load_a |=> !clk_out.load_a [*3])
		else $error("load pulses too close");
	a_pclk_a_rise: assert property (clk_out.load_a |-> $rose(clk_out.parallel_clock_out_a))
		else $error("word clock not rising at load");
	a_pclk_b_rise: assert property (clk_out.load_b |-> $rose(clk_out.parallel_clock_out_b))
		else $error("second clock not rising at load");
	a_cfg_relock: assert property (cfg_load && ce |=> ##1 !clk_out.locked)
		else $error("lock kept over reload");
	a_word_due: assert property (clk_out.load_a |-> ##8 rx_valid)
		else $error("word late");
	a_stall_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
		else $error("word lost in stall");
	a_ovf_sticky: assert property (rx_overflow |=> rx_overflow)
		else $error("overflow cleared");
	c_load: cover property (clk_out.load_a);
	c_ovf: cover property ($rose(rx_overflow));
	c_stall: cover property (rx_valid && !rx_ready);
endmodule : sdclk_top_assertions

bind sdclk_top sdclk_top_assertions #(.NCH(NCH), .WORD_W(WORD_W)) sdclk_top_assertions_i (.clk,
	.rst, .ce, .cfg_load, .clk_out, .rx_data, .rx_valid, .rx_ready, .rx_overflow);

// >>> testbench/sdclk_top_bench.sv
// self-checking bench for the serial clock generator and bit mapper
module sdclk_top_bench import sdclk_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int NCH = 18;
	typedef logic [NCH*8-1:0] sdclk_bus_t;
	logic clk, rst, cfg_load, rx_ready, rx_valid, rx_overflow, txref;
	logic armed = 1'b0;
	logic [1:0] src;
	sdclk_cfg_t cfg;
	logic [NCH-1:0][2:0] phase_sel;
	logic [NCH-1:0][3:0] w;
	logic [NCH-1:0] lanes;
	sdclk_clk_t clk_out;
	sdclk_bus_t rx_data, e;
	sdclk_bus_t exp_q[$];
	int n_errors = 0;
	int num_checks = 0;
	int seed = 2;
	sdclk_tx_model #(.NCH(NCH)) sdclk_tx_model_i (.ref_clk(txref), .lanes);
	sdclk_top #(.NCH(NCH)) sdclk_top_i (.clk, .rst, .ce(1'b1), .ref_pin(txref & src == 2'h0),
		.ref_pll(txref & src == 2'h1), .ref_core(txref & src == 2'h2), .cfg, .cfg_load,
		.phase_sel, .rx_serial(lanes), .clk_out, .rx_data, .rx_valid, .rx_ready, .rx_overflow);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(input string what, input sdclk_bus_t want, got);
		num_checks++;
		if (got !== want) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, want, got);
		end
	endtask : check
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	// idle-line words arrive before arming and are drained unchecked
	always @(posedge clk) if (armed && rx_valid === 1'b1 && rx_ready === 1'b1) begin
		if (exp_q.size() == 0) check("stray word", ~rx_data, rx_data);
		else check("rx_data", exp_q.pop_front(), rx_data);
	end
	initial begin
		#100000;
		n_errors++;
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		cfg_load = 1'b0;
		rx_ready = 1'b1;
		src = 2'h0;
		cfg = '0;
		phase_sel = '0;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		check("reset", '0, {clk_out, rx_valid, rx_overflow});
		$display("reset test done");
		// pass four: clock on pin, selection on pll, so no lock may appear
		for (int k = 0; k < 5; k++) begin
			src = 2'(k > 2 ? 0 : k);
			cfg = '{sdclk_ref_t'(k == 3 ? 1 : src), 4'h1, 4'h4, 4'h5, 4'h0, 1'b1, 1'b1};
			cfg_load = 1'b1;
			@(negedge clk);
			cfg_load = 1'b0;
			repeat (40) @(negedge clk);
			check("lock", {3{k != 3}}, clk_out[2:0]);
		end
		$display("reference test done");
		for (int c = 0; c < NCH; c++) phase_sel[c] = 3'($random(seed)) & 3'h3;
		for (int i = 0; i < 64 && clk_out.load_a !== 1'b1; i++) @(negedge clk);
		fork
			begin
				repeat (12) @(negedge clk);
				armed = 1'b1;
				rx_ready = 1'b0;
				repeat (110) @(negedge clk);
				repeat (300) begin
					rx_ready = 1'($random(seed));
					@(negedge clk);
				end
				rx_ready = 1'b1;
			end
			begin
				for (int n = 0; n < 9; n++) begin
					for (int c = 0; c < NCH; c++) begin
						w[c] = 4'($random(seed));
						e[c*8 +: 8] = {4'h0, w[c]};
					end
					// the third word meets a full buffer and is dropped
					if (n != 2) exp_q.push_back(e);
					sdclk_tx_model_i.send(w);
				end
				sdclk_tx_model_i.idle_lanes();
				// idle toggling keeps making words, so disarm as soon as the burst drains
				for (int i = 0; i < 99 && exp_q.size() > 0; i++) @(negedge clk);
				armed = 1'b0;
			end
		join
		check("overflow and queue", 9'h100, {rx_overflow, 8'(exp_q.size())});
		$display("stream test done");
		print_verdict();
	end
endmodule : sdclk_top_bench

// >>> testbench/sdclk_tx_model.sv
// forwarded-clock serial transmitter feeding the receive lanes
module sdclk_tx_model #(
	parameter int NCH = 18
) (
	// forwarded clock and serial lanes
	output logic ref_clk,
	output logic [NCH-1:0] lanes
);
	timeunit 1ns;
	timeprecision 1ns;
	logic busy = 1'b0;
	initial begin
		ref_clk = 1'b0;
		lanes = '0;
		forever #200 ref_clk = ~ref_clk;
	end
	// idle lanes flip every bit time so a stale bit never passes for data
	always @(posedge ref_clk) if (!busy) lanes <= ~lanes;
	// edge-aligned launch, msb first; busy stays set between calls so a burst is gapless
	task automatic send(input logic [NCH-1:0][3:0] w);
		busy <= 1'b1;
		for (int b = 3; b >= 0; b--) begin
			@(posedge ref_clk);
			for (int c = 0; c < NCH; c++) lanes[c] = w[c][b];
		end
	endtask : send
	// hands the lanes back to the idle toggle once a burst is done
	task automatic idle_lanes();
		busy <= 1'b0;
	endtask : idle_lanes
endmodule : sdclk_tx_model
